// ### core/coss_pkg.sv
// Package of constants and types for the contact output signal selector
package coss_pkg;

   // Signal type codes for outputs four to six
   typedef enum logic [4:0] {
      COSS_OFF = 5'h01,
      COSS_RUN = 5'h02,
      COSS_MODE = 5'h03,
      COSS_FAULT = 5'h04,
      COSS_WARNING = 5'h05,
      COSS_ALARM = 5'h06,
      COSS_MAINT = 5'h07,
      COSS_CH1_READY = 5'h08,
      COSS_CH2_READY = 5'h09,
      COSS_TEMP_OUT = 5'h0a,
      COSS_EXT_TEMP = 5'h0b,
      COSS_STARTUP = 5'h0c,
      COSS_ANTI_FREEZE = 5'h0d,
      COSS_WARM_UP = 5'h0e,
      COSS_DIN1 = 5'h0f,
      COSS_DIN2 = 5'h10,
      COSS_MODE_REQ = 5'h11,
      COSS_SEL_ALARM = 5'h12,
      COSS_SEL_MAINT = 5'h13
   } coss_type_t;

   // Number of configurable outputs
   localparam int COSS_NOUT = 3;
   // Width of the alarm status vector, bit n is alarm code n
   localparam int COSS_NALARM = 46;
   // Highest listed alarm code
   localparam logic [5:0] COSS_ALARM_MAX = 6'h2d;
   // Alarm codes driven by contact inputs one and two
   localparam int COSS_AL_DIN1 = 30;
   localparam int COSS_AL_DIN2 = 31;
   // Maintenance reminder count and code range
   localparam int COSS_NMAINT = 11;
   localparam logic [3:0] COSS_MAINT_MIN = 4'h1;
   localparam logic [3:0] COSS_MAINT_MAX = 4'ha;
   // Listed alarm codes as a mask (bits 0, 5, 7, 8, 28, 29, 32, 33 absent)
   localparam logic [45:0] COSS_ALARM_LIST = 46'h3ffc_cfff_fe5e;
   // Values after reset
   localparam coss_type_t COSS_TYPE_RST = COSS_OFF;
   localparam logic COSS_NC_RST = 1'b0;
   localparam logic [5:0] COSS_ASEL_RST = 6'h00;
   localparam logic [3:0] COSS_MSEL_RST = 4'h0;

endpackage : coss_pkg

// ### core/coss_source.sv
// One output's source selection and polarity
`timescale 1ns/1ps
`default_nettype none
module coss_source (
   input wire logic [4:0] sig_type,
   input wire logic nc_form,
   input wire logic [5:0] alarm_sel,
   input wire logic [3:0] maint_sel,
   input wire logic din1,
   input wire logic din2,
   input wire logic din3,
   input wire logic [45:0] alarm_vec,
   input wire logic [10:0] maint_vec,
   input wire logic [10:0] status,
   output logic level
);
   // Raw source before polarity
   logic raw;
   // Selected alarm bit, valid only for listed codes
   wire alarm_hit = (alarm_sel <= coss_pkg::COSS_ALARM_MAX)
                    && coss_pkg::COSS_ALARM_LIST[alarm_sel] && alarm_vec[alarm_sel]; // R7
   // Selected reminder bit, valid only for codes one to ten
   wire maint_hit = (maint_sel >= coss_pkg::COSS_MAINT_MIN)
                    && (maint_sel <= coss_pkg::COSS_MAINT_MAX) && maint_vec[maint_sel]; // R9

   // Source mux
   always_comb begin
      raw = 1'b0;
      unique case (sig_type)
         coss_pkg::COSS_RUN: raw = status[0];
         coss_pkg::COSS_MODE: raw = status[1];
         coss_pkg::COSS_FAULT: raw = status[2];
         coss_pkg::COSS_WARNING: raw = status[3];
         coss_pkg::COSS_ALARM: raw = status[4];
         coss_pkg::COSS_MAINT: raw = status[5];
         coss_pkg::COSS_CH1_READY: raw = status[6];
         coss_pkg::COSS_CH2_READY: raw = status[7];
         coss_pkg::COSS_TEMP_OUT: raw = status[8];
         coss_pkg::COSS_STARTUP: raw = status[9]; // R10
         coss_pkg::COSS_ANTI_FREEZE: raw = status[10]; // R10
         coss_pkg::COSS_WARM_UP: raw = maint_vec[0]; // R10
         coss_pkg::COSS_DIN1: raw = din1; // R2
         coss_pkg::COSS_DIN2: raw = din2; // R2
         coss_pkg::COSS_MODE_REQ: raw = din3; // R4
         coss_pkg::COSS_SEL_ALARM: raw = alarm_hit; // R5
         coss_pkg::COSS_SEL_MAINT: raw = maint_hit; // R6
         default: raw = 1'b0; // Off, external temp and illegal codes give a low source, open unless normally closed
      endcase
   end

   // Normally closed inverts every source, off included
   assign level = raw ^ nc_form; // R3
endmodule : coss_source
`default_nettype wire

// ### core/coss_top.sv
// Contact output selector for configurable outputs four to six
// How it works
// (R1) Outputs four-six: own type, form; default off/open
// (R2) Input one/two pass-through drives output directly
// (R3) Normally-closed form inverts the pass-through input
// (R4) Type seventeen passes the mode-request input
// (R5) Type eighteen follows one selected alarm
// (R6) Type nineteen follows one selected maintenance reminder
// (R7) Only listed alarm codes one to 45 select
// (R8) Alarms thirty, thirty-one follow contact inputs
// (R9) Reminder codes one to ten, one per output
// (R10) Setting types close contact while setting enabled
`timescale 1ns/1ps
`default_nettype none
module coss_top (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CE,
   input wire logic [14:0] TYPE_CFG,
   input wire logic [2:0] NC_CFG,
   input wire logic [17:0] ALARM_SEL_CFG,
   input wire logic [11:0] MAINT_SEL_CFG,
   input wire logic [2:0] CONTACT_IN,
   input wire logic [45:0] ALARM_IN,
   input wire logic [10:0] MAINT_IN,
   input wire logic [10:0] STATUS_IN,
   input wire logic WARM_UP_IN,
   output logic [2:0] CONTACT_OUT,
   output logic [45:0] ALARM_OUT
);
   // Contact pins come from outside, two flops each
   logic [2:0] din_meta;
   logic [2:0] din_sync;
   // Held configuration per output
   // Highest output index
   localparam int COSS_N_LIM = coss_pkg::COSS_NOUT - 1;
   logic [4:0] sig_type [COSS_N_LIM:0];
   logic [2:0] nc_form;
   logic [5:0] alarm_sel [COSS_N_LIM:0];
   logic [3:0] maint_sel [COSS_N_LIM:0];
   // Combined alarm vector with contact input alarms merged in
   wire [45:0] alarm_all;
   // Per-output selected level
   wire [2:0] next_out;
   // Maintenance vector with warm-up setting on spare bit zero
   wire [10:0] maint_ext = {MAINT_IN[10:1], WARM_UP_IN};

   // Input synchroniser
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         din_meta <= 3'h0;
         din_sync <= 3'h0;
      end else if (CE) begin
         din_meta <= CONTACT_IN;
         din_sync <= din_meta;
      end
   end

   // Contact inputs one and two alone raise their alarms; the alarm bus bits are ignored
   assign alarm_all = ALARM_IN
      & ~((46'h1 << coss_pkg::COSS_AL_DIN1) | (46'h1 << coss_pkg::COSS_AL_DIN2))
      | (46'h1 << coss_pkg::COSS_AL_DIN1) & {46{din_sync[0]}}
      | (46'h1 << coss_pkg::COSS_AL_DIN2) & {46{din_sync[1]}}; // R8

   // Configuration registers, default off and normally open
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         for (int i = 0; i < coss_pkg::COSS_NOUT; i++) begin
            sig_type[i] <= coss_pkg::COSS_TYPE_RST; // R1
            alarm_sel[i] <= coss_pkg::COSS_ASEL_RST;
            maint_sel[i] <= coss_pkg::COSS_MSEL_RST;
         end
         nc_form <= {3{coss_pkg::COSS_NC_RST}}; // R1
      end else if (CE) begin
         for (int i = 0; i < coss_pkg::COSS_NOUT; i++) begin
            sig_type[i] <= TYPE_CFG[i*5 +: 5];
            alarm_sel[i] <= ALARM_SEL_CFG[i*6 +: 6];
            maint_sel[i] <= MAINT_SEL_CFG[i*4 +: 4];
         end
         nc_form <= NC_CFG;
      end
   end

   // One selector per output
   genvar g;
   generate
      for (g = 0; g < coss_pkg::COSS_NOUT; g++) begin : g_out
         coss_source u_src (
            .sig_type(sig_type[g]),
            .nc_form(nc_form[g]),
            .alarm_sel(alarm_sel[g]),
            .maint_sel(maint_sel[g]),
            .din1(din_sync[0]),
            .din2(din_sync[1]),
            .din3(din_sync[2]),
            .alarm_vec(alarm_all),
            .maint_vec(maint_ext),
            .status(STATUS_IN),
            .level(next_out[g])
         );
      end
   endgenerate

   // Registered contact drive and alarm status
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         CONTACT_OUT <= 3'h0;
         ALARM_OUT <= 46'h0;
      end else if (CE) begin
         CONTACT_OUT <= next_out; // R2
         ALARM_OUT <= alarm_all & coss_pkg::COSS_ALARM_LIST; // R8
      end
   end
endmodule : coss_top
`default_nettype wire

// ### tb/coss_monitor.sv
// Port checker for the contact output selector
`timescale 1ns/1ps
`default_nettype none
module coss_monitor (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic CE,
   input wire logic WARM_UP_IN,
   input wire logic [2:0] NC_CFG,
   input wire logic [2:0] CONTACT_IN,
   input wire logic [2:0] CONTACT_OUT,
   input wire logic [14:0] TYPE_CFG,
   input wire logic [17:0] ALARM_SEL_CFG,
   input wire logic [11:0] MAINT_SEL_CFG,
   input wire logic [10:0] MAINT_IN,
   input wire logic [45:0] ALARM_IN,
   input wire logic [45:0] ALARM_OUT
);
   // Type field of each output
   wire [4:0] t4 = TYPE_CFG[4:0];
   wire [4:0] t5 = TYPE_CFG[9:5];
   wire [4:0] t6 = TYPE_CFG[14:10];
   default clocking @(posedge CLK); endclocking
   // Frozen cycles start no check
   default disable iff (!RESET_N || !CE);
   a_off_open: assert property ((t6 == 5'h01 && !NC_CFG[2])[*4]
      |-> !CONTACT_OUT[2]) else $error("off closed");
   a_din1_direct: assert property ((t4 == 5'h0f && !NC_CFG[0] && CONTACT_IN[0])[*5]
      |-> CONTACT_OUT[0]) else $error("din1 lost");
   a_din2_invert: assert property ((t5 == 5'h10 && NC_CFG[1] && CONTACT_IN[1])[*5]
      |-> !CONTACT_OUT[1]) else $error("din2 kept");
   a_sel_alarm: assert property ((t4 == 5'h12 && !NC_CFG[0] && ALARM_IN[2]
      && ALARM_SEL_CFG[5:0] == 6'h02)[*4] |-> CONTACT_OUT[0]) else $error("alarm lost");
   a_sel_maint: assert property ((t5 == 5'h13 && NC_CFG[1] && MAINT_IN[10]
      && MAINT_SEL_CFG[7:4] == 4'ha)[*4] |-> !CONTACT_OUT[1]) else $error("reminder lost");
   a_unlisted_zero: assert property ((ALARM_OUT & ~coss_pkg::COSS_ALARM_LIST) == 46'h0)
      else $error("unlisted alarm");
   a_din_alarm: assert property (CONTACT_IN[1][*5] |-> ALARM_OUT[31])
      else $error("alarm 31 lost");
   a_warm_up: assert property ((t4 == 5'h0e && !NC_CFG[0] && WARM_UP_IN)[*4]
      |-> CONTACT_OUT[0]) else $error("warm-up open");
   c_din1: cover property (CONTACT_OUT[0] && CONTACT_IN[0]);
   c_al30: cover property (ALARM_OUT[30]);
   c_all: cover property (CONTACT_OUT == 3'h7);
endmodule : coss_monitor
`default_nettype wire

// ### tb/coss_equip.sv
// Customer switches wired to the contact inputs
`timescale 1ns/1ps
`default_nettype none
module coss_equip (
   input wire logic [2:0] sw,
   output logic [2:0] contact
);
   // Contacts settle a little after the switch moves
   assign #1 contact = sw;
endmodule : coss_equip
`default_nettype wire

// ### tb/tb.sv
// Bench for the contact output selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
$display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
   logic clk = 0, reset_n = 0, ce = 1, warm = 0;
   logic [14:0] ty = 15'h0421;
   logic [2:0] nc = 0, sw = 0, cin, cout;
   logic [17:0] asel = 0;
   logic [11:0] msel = 0;
   logic [45:0] ain = 0, aout;
   logic [10:0] mt = 0, st = 0;
   int error_cnt = 0, checked = 0;
   always #2 clk = ~clk;
   coss_top u_dut (.CLK(clk), .RESET_N(reset_n), .CE(ce), .TYPE_CFG(ty), .NC_CFG(nc),
      .ALARM_SEL_CFG(asel), .MAINT_SEL_CFG(msel), .CONTACT_IN(cin), .ALARM_IN(ain),
      .MAINT_IN(mt), .STATUS_IN(st), .WARM_UP_IN(warm), .CONTACT_OUT(cout), .ALARM_OUT(aout));
   coss_equip u_eq (.sw(sw), .contact(cin));
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic t_off;
      `CHK(cout, 3'h0)
      nc = 7;
      step(3);
      `CHK(cout, 3'h7)
   endtask : t_off
   task automatic t_pass;
      ty = 15'h460f;
      nc = 2;
      for (int i = 0; i < 8; i++) begin
         sw = i[2:0];
         step(6);
         `CHK(cout, sw ^ 3'h2)
         `CHK(aout[31:30], sw[1:0])
      end
   endtask : t_pass
   task automatic t_alarm;
      ty = 15'h0432;
      nc = 0;
      sw = 0;
      for (int i = 0; i < 64; i++) begin
         asel = 18'(i);
         ain = (i < 46) ? 46'h1 << i : '1;
         step(5);
         `CHK(cout[0], i < 46 && coss_pkg::COSS_ALARM_LIST[i[5:0]] && i / 2 != 15)
         `CHK(aout, ain & coss_pkg::COSS_ALARM_LIST & ~(46'h3 << 30))
      end
      asel = 18'h1e;
      sw = 1;
      step(6);
      `CHK(cout[0], 1'b1)
   endtask : t_alarm
   task automatic t_maint;
      ty = 15'h0661;
      nc = 2;
      mt = 11'h7ff;
      for (int i = 0; i < 16; i++) begin
         msel = 12'(i << 4);
         step(5);
         `CHK(cout[1], !(i > 0 && i < 11))
      end
   endtask : t_maint
   task automatic t_set;
      nc = 0;
      for (int i = 0; i < 3; i++) begin
         ty = 15'h0420 | 15'(12 + i);
         {st[9], st[10], warm} = 3'h4 >> i;
         step(4);
         `CHK(cout[0], 1'b1)
      end
      ce = 0;
      warm = 0;
      step(4);
      `CHK(cout[0], 1'b1)
      ce = 1;
      step(3);
      `CHK(cout[0], 1'b0)
   endtask : t_set
   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      step(16);
      reset_n = 1;
      step(3);
      t_off;
      t_pass;
      t_alarm;
      t_maint;
      t_set;
      close_out;
   end
   initial begin
      #20000;
      error_cnt++;
      close_out;
   end
endmodule : tb
bind coss_top coss_monitor u_mon (.*);
`default_nettype wire
